// ===== src/cdf_formatter.v
// diagnostic can identifier builder, frame formatter and response text generator
// Summary of operation
// [RULE_01] four-byte header: drop top three bits, low 29 bits become transmit identifier
// [RULE_02] priority byte plus three header bytes combine into one 29-bit identifier
// [RULE_03] priority byte resets to hex 18
// [RULE_04] extended message type byte is DB functional, DA physical
// [RULE_05] extended functional target 33, source F1 in last two bytes
// [RULE_06] three-digit header: use low 11 bits, ignore the top bit
// [RULE_07] standard functional requests use 7DF, physical replies use 7En
// [RULE_08] request identifier 7E0 addresses the module replying as 7E8
// [RULE_09] only frames passing the receive filter reach the host; default accepts 7En
// [RULE_10] single frame: pci byte holds data count, at most seven bytes
// [RULE_11] auto format adds pci on send, strips it on receive; shown with identifiers
// [RULE_12] auto format off: bytes sent unchanged, padded to eight
// [RULE_13] first frame carries 12-bit total length, at most 4095
// [RULE_14] consecutive frames carry sequence digit 0 to F, wrapping
// [RULE_15] first frame received: transmit predefined flow control frame at once
// [RULE_16] flow control frames print with prefix FC and colon
// [RULE_17] rtr flag or zero length prints RTR when formatting off or identifiers shown
// [RULE_18] formatted multiframe lines begin with sequence digit and colon
// [RULE_19] formatted first frame length prints as three hex digits on its own line
// [RULE_20] identifier and pci bytes hidden unless identifier display is on; code also shows them whenever auto format is off
// [RULE_21] crc never shown
// [RULE_22] multiframe data reported in received sequence order, uninterpreted
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cdf_map.vh"
module cdf_formatter (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // can transmit frame
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [28:0] tx_id,
  output reg         tx_ext,
  output reg  [63:0] tx_data,
  output reg  [3:0]  tx_dlc,
  // can receive frame
  input  wire        rx_valid,
  input  wire [28:0] rx_id,
  input  wire        rx_ext,
  input  wire        rx_rtr,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  // text stream to host
  output reg         txt_valid,
  output reg  [7:0]  txt_char,
  input  wire        txt_ready,
  output reg         rx_busy
);
  // states of text generator
  localparam S_IDLE = 3'd0;
  localparam S_EMIT = 3'd1;
  // registers
  reg [2:0]  ctrl_r;
  reg [7:0]  prio_r;
  reg [31:0] hdr_r;
  reg        hdr_long_r;
  reg [63:0] txd_r;
  reg [3:0]  txlen_r;
  reg [10:0] filt_id_r;
  reg [10:0] filt_mask_r;
  reg [28:0] fcid_r;
  reg [7:0]  dropped_r;
  reg [3:0]  last_seq_r;
  reg        fc_pend_r;
  reg        tx_pend_r;
  reg        tx_fc_r;
  // line buffer for one output line
  reg [7:0]  line_r [0:47];
  reg [5:0]  line_len_r;
  reg [5:0]  line_pos_r;
  reg [2:0]  st_r;
  reg [7:0]  line_nxt [0:47];
  reg [5:0]  line_len_nxt;
  wire [28:0] txid_cur;
  wire        acc_w;
  wire        wr_w;
  wire        filt_ok;
  wire [3:0]  pci_type;
  wire        is_rtr;
  wire [7:0]  hc [0:15];
  wire [3:0]  nibs [0:15];
  wire [63:0] txd_pad;
  integer     i;
  integer     j;
  reg [5:0]   n;
  reg [3:0]   first_b;
  reg [3:0]   k;
  assign acc_w = psel & penable & ~pready;
  assign wr_w  = acc_w & pwrite;
  // extended: priority byte over three header bytes, or raw 29 bits of a four-byte header
  assign txid_cur = hdr_long_r ? hdr_r[28:0] : {prio_r[4:0], hdr_r[23:0]}; // RULE_01 RULE_02
  // default filter passes 7En replies
  assign filt_ok = ~rx_ext & ((rx_id[10:0] & filt_mask_r) == (filt_id_r & filt_mask_r)); // RULE_09
  assign pci_type = rx_data[63:60];
  assign is_rtr = rx_rtr | (rx_dlc == 4'h0); // RULE_17
  wire show_w = ctrl_r[`CDF_CTRL_SHOWID] | ~ctrl_r[`CDF_CTRL_AUTOFMT]; // RULE_20
  wire take_w = rx_valid & filt_ok & (~is_rtr | show_w); // RULE_17
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_byte
      assign txd_pad[63-8*g -: 8] = (g < txlen_r) ? txd_r[63-8*g -: 8] : `CDF_PAD_BYTE; // RULE_12
      assign nibs[2*g]   = rx_data[63-8*g -: 4];
      assign nibs[2*g+1] = rx_data[59-8*g -: 4];
      cdf_hex u_hx0 (.nib(nibs[2*g]), .chr(hc[2*g]));
      cdf_hex u_hx1 (.nib(nibs[2*g+1]), .chr(hc[2*g+1]));
    end
  endgenerate
  wire [7:0] idc0;
  wire [7:0] idc1;
  wire [7:0] idc2;
  wire [7:0] lnc0;
  cdf_hex u_id0 (.nib({1'b0, rx_id[10:8]}), .chr(idc0));
  cdf_hex u_id1 (.nib(rx_id[7:4]), .chr(idc1));
  cdf_hex u_id2 (.nib(rx_id[3:0]), .chr(idc2));
  cdf_hex u_ln0 (.nib(rx_data[59:56]), .chr(lnc0));
  // apb register access
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r      <= `CDF_CTRL_RESET;
      prio_r      <= `CDF_PRIO_RESET; // RULE_03
      hdr_r       <= `CDF_HDR_RESET;  // RULE_07
      hdr_long_r  <= 1'b0;
      txd_r       <= 64'h0;
      txlen_r     <= 4'h0;
      filt_id_r   <= `CDF_FILT_ID_RESET;
      filt_mask_r <= `CDF_FILT_MASK_RESET;
      fcid_r      <= `CDF_FCID_RESET;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0;
      tx_pend_r   <= 1'b0;
    end else begin
      pready  <= acc_w;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (tx_valid & tx_ready & ~tx_fc_r) begin
        tx_pend_r <= 1'b0;
      end
      if (acc_w) begin
        case (paddr)
          `CDF_REG_CTRL: begin
            if (wr_w) ctrl_r <= pwdata[2:0];
            prdata <= {29'h0, ctrl_r};
          end
          `CDF_REG_PRIO: begin
            if (wr_w) prio_r <= pwdata[7:0];
            prdata <= {24'h0, prio_r};
          end
          `CDF_REG_HDR: begin
            // bit 31 marks a full four-byte header; low 11 bits serve standard ids
            if (wr_w) begin
              hdr_r      <= {3'h0, pwdata[28:0]};
              hdr_long_r <= pwdata[31];
            end
            prdata <= {hdr_long_r, 2'h0, hdr_r[28:0]};
          end
          `CDF_REG_TXCMD: begin
            if (wr_w & ~tx_pend_r) begin
              txlen_r   <= pwdata[3:0];
              tx_pend_r <= 1'b1;
            end
            prdata <= {31'h0, tx_pend_r};
          end
          `CDF_REG_TXD0: begin
            if (wr_w) txd_r[63:32] <= pwdata;
            prdata <= txd_r[63:32];
          end
          `CDF_REG_TXD1: begin
            if (wr_w) txd_r[31:0] <= pwdata;
            prdata <= txd_r[31:0];
          end
          `CDF_REG_TXID: prdata <= {3'h0, txid_cur};
          `CDF_REG_FILT: begin
            if (wr_w) begin
              filt_id_r   <= pwdata[10:0];
              filt_mask_r <= pwdata[26:16];
            end
            prdata <= {5'h0, filt_mask_r, 5'h0, filt_id_r};
          end
          `CDF_REG_RXSTAT: prdata <= {20'h0, last_seq_r, dropped_r};
          `CDF_REG_FCID: begin
            if (wr_w) fcid_r <= pwdata[28:0];
            prdata <= {3'h0, fcid_r};
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // transmit path; flow control has priority over host requests
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_id    <= 29'h0;
      tx_ext   <= 1'b0;
      tx_data  <= 64'h0;
      tx_dlc   <= 4'h0;
      tx_fc_r  <= 1'b0;
    end else if (~tx_valid | tx_ready) begin
      tx_valid <= 1'b0;
      if (fc_pend_r & ~(tx_valid & tx_fc_r)) begin
        tx_valid <= 1'b1; // RULE_15
        tx_fc_r  <= 1'b1;
        tx_ext   <= ctrl_r[`CDF_CTRL_EXT];
        tx_id    <= ctrl_r[`CDF_CTRL_EXT] ? fcid_r : {18'h0, fcid_r[10:0]};
        tx_data  <= {`CDF_FC_BYTE0, 56'h0};
        tx_dlc   <= `CDF_FRAME_BYTES;
      end else if (tx_pend_r & ~(tx_valid & ~tx_fc_r)) begin
        tx_valid <= 1'b1;
        tx_fc_r  <= 1'b0;
        tx_ext   <= ctrl_r[`CDF_CTRL_EXT];
        // standard ids keep the low 11 bits only
        tx_id    <= ctrl_r[`CDF_CTRL_EXT] ? txid_cur : {18'h0, hdr_r[10:0]}; // RULE_06
        tx_dlc   <= `CDF_FRAME_BYTES; // RULE_12
        if (ctrl_r[`CDF_CTRL_AUTOFMT]) begin
          // pci byte carries count; count is clipped to seven, rest padded
          tx_data <= {`CDF_PCI_SF, (txlen_r > `CDF_SF_MAX) ? `CDF_SF_MAX : txlen_r,
                      txd_pad[63:8]}; // RULE_10 RULE_11
        end else begin
          tx_data <= txd_pad; // RULE_12
        end
      end
    end
  end
  // text line for the frame on the receive inputs; frames carry no crc field to show
  always @* begin
    n       = 6'd0;
    first_b = 4'h0;
    k       = 4'h0;
    for (i = 0; i < 48; i = i + 1) line_nxt[i] = `CDF_CH_SPACE;
    if (show_w) begin
      line_nxt[0] = idc0; // RULE_20
      line_nxt[1] = idc1;
      line_nxt[2] = idc2;
      n = 6'd4;
    end
    if (is_rtr) begin
      line_nxt[n]   = `CDF_CH_R; // RULE_17
      line_nxt[n+1] = `CDF_CH_T;
      line_nxt[n+2] = `CDF_CH_R;
      n = n + 6'd3;
    end else begin
      if (pci_type == `CDF_PCI_FC) begin
        line_nxt[n]   = `CDF_CH_FC; // RULE_16
        line_nxt[n+1] = `CDF_CH_C;
        line_nxt[n+2] = `CDF_CH_COLON;
        n = n + 6'd4;
      end else if (~show_w) begin
        first_b = 4'h1; // RULE_11
        if (pci_type == `CDF_PCI_FF) begin
          line_nxt[n]   = lnc0; // RULE_13 RULE_19
          line_nxt[n+1] = hc[2];
          line_nxt[n+2] = hc[3];
          line_nxt[n+3] = `CDF_CH_CR;
          line_nxt[n+4] = 8'h30; // RULE_18
          line_nxt[n+5] = `CDF_CH_COLON;
          n = n + 6'd7;
          first_b = 4'h2;
        end else if (pci_type == `CDF_PCI_CF) begin
          line_nxt[n]   = hc[1]; // RULE_14 RULE_18 RULE_22
          line_nxt[n+1] = `CDF_CH_COLON;
          n = n + 6'd3;
        end
      end
      for (i = 0; i < 8; i = i + 1) begin
        k = i[3:0];
        if ((k >= first_b) && (k < rx_dlc)) begin
          line_nxt[n]   = hc[2*i];
          line_nxt[n+1] = hc[2*i+1];
          n = n + 6'd3;
        end
      end
    end
    line_nxt[n]  = `CDF_CH_CR; // RULE_21
    line_len_nxt = n + 6'd1;
  end
  // receive: one text line per accepted frame
  always @(posedge clk) begin
    if (sys_rst) begin
      st_r       <= S_IDLE;
      line_len_r <= 6'd0;
      line_pos_r <= 6'd0;
      txt_valid  <= 1'b0;
      txt_char   <= 8'h0;
      rx_busy    <= 1'b0;
      fc_pend_r  <= 1'b0;
      dropped_r  <= 8'h0;
      last_seq_r <= 4'h0;
    end else begin
      if (tx_valid & tx_ready & tx_fc_r) fc_pend_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          txt_valid  <= 1'b0;
          rx_busy    <= take_w;
          line_pos_r <= 6'd0;
          if (rx_valid & ~filt_ok) dropped_r <= dropped_r + 8'h01; // RULE_09
          if (take_w) begin
            for (j = 0; j < 48; j = j + 1) line_r[j] <= line_nxt[j];
            line_len_r <= line_len_nxt;
            st_r       <= S_EMIT;
          end
          if (take_w & ~is_rtr & (pci_type == `CDF_PCI_FF)) begin
            fc_pend_r  <= 1'b1; // RULE_15
            last_seq_r <= 4'h0;
          end
          if (take_w & ~is_rtr & (pci_type == `CDF_PCI_CF)) last_seq_r <= rx_data[59:56]; // RULE_14
        end
        S_EMIT: begin
          rx_busy <= 1'b1;
          if (~txt_valid | txt_ready) begin
            if (line_pos_r == line_len_r) begin
              txt_valid <= 1'b0;
              rx_busy   <= 1'b0;
              st_r      <= S_IDLE;
            end else begin
              txt_valid  <= 1'b1;
              txt_char   <= line_r[line_pos_r];
              line_pos_r <= line_pos_r + 6'd1;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== src/cdf_map.vh
// register offsets, field positions, reset values and protocol constants of the diagnostic frame formatter
`ifndef CDF_MAP_VH
`define CDF_MAP_VH
`define CDF_REG_CTRL       12'h000
`define CDF_REG_PRIO       12'h004
`define CDF_REG_HDR        12'h008
`define CDF_REG_TXCMD      12'h00c
`define CDF_REG_TXD0       12'h010
`define CDF_REG_TXD1       12'h014
`define CDF_REG_TXID       12'h018
`define CDF_REG_FILT       12'h01c
`define CDF_REG_RXSTAT     12'h020
`define CDF_REG_FCID       12'h024
`define CDF_CTRL_AUTOFMT   0
`define CDF_CTRL_SHOWID    1
`define CDF_CTRL_EXT       2
`define CDF_CTRL_RESET     3'h1
`define CDF_PRIO_RESET     8'h18
`define CDF_HDR_RESET      32'h000007df
`define CDF_FILT_ID_RESET  11'h7e0
`define CDF_FILT_MASK_RESET 11'h7f0
`define CDF_FCID_RESET     29'h000007e0
`define CDF_PCI_SF         4'h0
`define CDF_PCI_FF         4'h1
`define CDF_PCI_CF         4'h2
`define CDF_PCI_FC         4'h3
`define CDF_PAD_BYTE       8'h00
`define CDF_FC_BYTE0       8'h30
`define CDF_SF_MAX         4'h7
`define CDF_FRAME_BYTES    4'h8
`define CDF_CH_FC          8'h46
`define CDF_CH_C           8'h43
`define CDF_CH_COLON       8'h3a
`define CDF_CH_SPACE       8'h20
`define CDF_CH_R           8'h52
`define CDF_CH_T           8'h54
`define CDF_CH_CR          8'h0d
`endif

// ===== src/cdf_hex.v
// converts one nibble to its ascii hex character
`timescale 1ns/1ps
`default_nettype none
module cdf_hex (
  // nibble in
  input  wire [3:0] nib,
  // character out
  output reg  [7:0] chr
);
  always @* begin
    if (nib < 4'ha) begin
      chr = {4'h3, nib};
    end else begin
      chr = 8'h37 + {4'h0, nib};
    end
  end
endmodule
`default_nettype wire

// ===== testbench/cdf_assertions.sv
// port assertions for the diagnostic frame formatter
`timescale 1ns/1ps
`default_nettype none
module cdf_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // can frames
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [63:0] tx_data,
  input wire logic [3:0]  tx_dlc,
  input wire logic        rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic        rx_ext,
  input wire logic        rx_rtr,
  input wire logic [63:0] rx_data,
  // text stream
  input wire logic        txt_valid,
  input wire logic        txt_ready,
  input wire logic [7:0]  txt_char,
  input wire logic        rx_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // idle data frame inside the default 7en window
  logic pass_w;
  assign pass_w = rx_valid && !rx_busy && !rx_ext && !rx_rtr && rx_id[10:4] == 7'h7e;
  sequence s_line;
    rx_busy ##1 txt_valid;
  endsequence
  sequence s_fc_out;
    tx_valid && tx_data[63:56] == 8'h30;
  endsequence
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer not after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame changed before taken");
  property p_dlc; tx_valid |-> tx_dlc == 4'h8; endproperty
  a_dlc: assert property (p_dlc) else $error("frame not eight bytes");
  property p_txt_hold; txt_valid && !txt_ready |=> txt_valid && $stable(txt_char); endproperty
  a_txt_hold: assert property (p_txt_hold) else $error("text char dropped");
  property p_line; pass_w |=> s_line; endproperty
  a_line: assert property (p_line) else $error("accepted frame not shown");
  property p_fc; pass_w && rx_data[63:60] == 4'h1 |-> ##[1:40] s_fc_out; endproperty
  a_fc: assert property (p_fc) else $error("no flow control after first frame");
endmodule
bind cdf_formatter cdf_assertions chk_u (.*);
`default_nettype wire

// ===== testbench/cdf_ecu_model.sv
// can controller and ecu stand-in facing the formatter
`timescale 1ns/1ps
`default_nettype none
module cdf_ecu_model (
  // clock
  input  wire logic        clk,
  // frames from the formatter
  input  wire logic        tx_valid,
  output logic             tx_ready = 1'b0,
  input  wire logic [28:0] tx_id,
  input  wire logic        tx_ext,
  input  wire logic [63:0] tx_data,
  // frames to the formatter
  output logic             rx_valid = 1'b0,
  output logic [28:0]      rx_id = 29'h0,
  output logic             rx_ext = 1'b0,
  output logic             rx_rtr = 1'b0,
  output logic [3:0]       rx_dlc = 4'h0,
  output logic [63:0]      rx_data = 64'h0
);
  int          stall = 0;
  int          wait_n = 0;
  int          got_n = 0;
  logic [28:0] got_id;
  logic        got_ext;
  logic [63:0] got_data;
  // takes a frame after a programmable stall
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got_id <= tx_id;
      got_ext <= tx_ext;
      got_data <= tx_data;
      got_n <= got_n + 1;
      tx_ready <= 1'b0;
      wait_n <= 0;
    end else if (tx_valid && wait_n >= stall) tx_ready <= 1'b1;
    else if (tx_valid) wait_n <= wait_n + 1;
  end
  // released id and data lines show the inverse of the last frame; rtr and dlc keep their values
  task automatic send(input logic [28:0] id, input logic [63:0] d, input logic [3:0] n, input logic rtr);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_rtr <= rtr;
    rx_dlc <= n;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the diagnostic frame formatter
`timescale 1ns/1ps
`default_nettype none
`include "cdf_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        psel = 0, penable = 0, pwrite = 0, txt_ready = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic        pready, pslverr, erv, tx_valid, tx_ready, tx_ext, rx_valid, rx_ext, rx_rtr, txt_valid, rx_busy;
  logic [28:0] tx_id, rx_id;
  logic [63:0] tx_data, rx_data;
  logic [3:0]  tx_dlc, rx_dlc;
  logic [7:0]  txt_char;
  logic [7:0]  q[$];
  int          num_errors = 0, checks_done = 0, seen = 0;
  cdf_formatter dut_u (.*);
  cdf_ecu_model ecu_u (.*);
  always #5 clk = ~clk;
  // host side stalls every other cycle; spaces are dropped from the capture
  always @(posedge clk) begin
    txt_ready <= ~txt_ready;
    if (txt_valid && txt_ready && txt_char != `CDF_CH_SPACE) q.push_back(txt_char);
  end
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin num_errors++; end_sim; end
    rdv = prdata;
    erv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rdv, e)
  endtask
  task automatic txc(input logic [28:0] id, input logic [63:0] d, input logic x);
    int i;
    i = 0;
    while (ecu_u.got_n == seen && i < 200) begin @(posedge clk); i++; end
    if (i >= 200) begin num_errors++; end_sim; end
    seen = ecu_u.got_n;
    `CHK(ecu_u.got_id, id)
    `CHK(ecu_u.got_data, d)
    `CHK(ecu_u.got_ext, x)
  endtask
  task automatic rxl(input logic [28:0] id, input logic [63:0] d, input logic [3:0] n, input logic r, input string s);
    int i;
    q.delete();
    ecu_u.send(id, d, n, r);
    i = 0;
    do begin @(posedge clk); i++; end while ((rx_busy !== 1'b0 || i < 4) && i < 400);
    if (i >= 400) begin num_errors++; end_sim; end
    repeat (2) @(posedge clk);
    `CHK(q.size(), s.len())
    for (i = 0; i < s.len() && i < q.size(); i++) `CHK(q[i], s[i])
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rd(`CDF_REG_CTRL, 32'h1);
    rd(`CDF_REG_PRIO, 32'h18);
    rd(`CDF_REG_FILT, 32'h07f007e0);
    apb(0, 12'h040, 0);
    `CHK(erv, 1'b1)
    apb(1, `CDF_REG_TXD0, 32'h01000000);
    apb(1, `CDF_REG_TXCMD, 32'h2);
    txc(29'h7df, 64'h0201000000000000, 1'b0);
    ecu_u.stall = 3;
    apb(1, `CDF_REG_CTRL, 32'h0);
    apb(1, `CDF_REG_HDR, 32'hfe0);
    apb(1, `CDF_REG_TXD0, 32'h02010dee);
    apb(1, `CDF_REG_TXD1, 32'h11223344);
    apb(1, `CDF_REG_TXCMD, 32'h3);
    txc(29'h7e0, 64'h02010d0000000000, 1'b0);
    apb(1, `CDF_REG_CTRL, 32'h5);
    apb(1, `CDF_REG_HDR, 32'h00db33f1);
    rd(`CDF_REG_TXID, 32'h18db33f1);
    apb(1, `CDF_REG_TXCMD, 32'h2);
    txc(29'h18db33f1, 64'h0202010000000000, 1'b1);
    apb(1, `CDF_REG_HDR, 32'hf8da10f1);
    rd(`CDF_REG_TXID, 32'h18da10f1);
    apb(1, `CDF_REG_CTRL, 32'h1);
    rxl(29'h7e8, 64'h0341054600000000, 4'h4, 0, "410546\r");
    rxl(29'h7e8, 64'h1014490201314434, 4'h8, 0, "014\r0:490201314434\r");
    txc(29'h7e0, 64'h3000000000000000, 1'b0);
    rxl(29'h7e8, 64'h2147503030523535, 4'h8, 0, "1:47503030523535\r");
    rxl(29'h7e8, 64'h2f01020304050607, 4'h8, 0, "F:01020304050607\r");
    rxl(29'h7e8, 64'h2008090a0b0c0d0e, 4'h8, 0, "0:08090A0B0C0D0E\r");
    rxl(29'h7e8, 64'h3000000000000000, 4'h8, 0, "FC:3000000000000000\r");
    rxl(29'h7df, 64'h0341054600000000, 4'h4, 0, "");
    apb(0, `CDF_REG_RXSTAT, 0);
    `CHK(rdv[7:0], 8'h01)
    rxl(29'h7e8, 64'h0, 4'h0, 1, "");
    apb(1, `CDF_REG_CTRL, 32'h3);
    rxl(29'h7e8, 64'h0341054600000000, 4'h4, 0, "7E803410546\r");
    rxl(29'h7e8, 64'h0, 4'h0, 1, "7E8RTR\r");
    end_sim;
  end
endmodule
`default_nettype wire
